// >>> design/cld_decoder.sv
// Purpose: Instruction interpreter of a character display controller.
// Assumes: Host strobes are synchronous to clk; one strobe per cycle at most.
// Notes:   Clear and home are not handled; ROM glyphs and drivers live elsewhere.
`timescale 1ns/1ps
// Overview of operation
// - Entry mode 04h-07h; increment bit picks counter direction after RAM access.
// - Shift-enable moves display as well as cursor after text RAM writes.
// - Entry-mode display shift goes opposite to cursor direction.
// - Text reads and all glyph accesses move cursor only.
// - Both lines share one shift offset, so they move together.
// - On/off command holds display, cursor and blink flags.
// - Blink toggles dark phase, full period 204800 clocks.
// - Shift command 10h-1Fh: select bit moves display and cursor or cursor only.
// - Direction bit: 1 right, 0 left.
// - Width bit selects 8-bit or 4-bit bus.
// - Lines and font select duty 1/8, 1/11 or 1/16.
// - Glyph address command loads 6-bit counter and selects glyph RAM.
// - Glyph addressing wraps 3Fh to 00h.
// - Text address command loads 7-bit counter and selects text RAM.
// - Text RAM 80 cells; valid ranges depend on line count.
// - Data write stores byte at counter in selected RAM, then steps.
// - Glyph upper three bits stored but masked from pixels.
// - Status read gives busy in bit 7 and counter below.
// - After address load a 5-clock settle follows busy; counter valid at once.
// - Data read returns selected RAM byte and steps, never shifts.
// - Every instruction busy for at least 10 clocks.
module cld_decoder
#(
    parameter int BLINK_HALF = cld_pkg::CLD_BLINK_HALF
)
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       nrst,
    // Host port
    input  wire logic       register_select,
    input  wire logic [7:0] wdata,
    input  wire logic       wr_stb,
    input  wire logic       rd_stb,
    output logic      [7:0] rdata,
    // Display state
    output logic            busy_indicator,
    output logic      [6:0] addr_count,
    output logic            sel_glyph,
    output logic      [6:0] shift_ofs,
    output logic            disp_on,
    output logic            cursor_on,
    output logic            blink_on,
    output logic            blink_dark,
    output logic            bus_8bit,
    output logic            two_line,
    output logic      [4:0] duty_coms,
    // Glyph pixel readback for the display side
    input  wire logic [5:0] pix_addr,
    output logic      [4:0] pix_row
);
    import cld_pkg::*;

    typedef struct packed {
        cld_state_e  st;
        logic [8:0]  cnt;
        logic [6:0]  ac;
        logic        glyph;
        logic [6:0]  ofs;
        logic        inc;
        logic        shen;
        logic        disp;
        logic        curs;
        logic        blink;
        logic        ifw;
        logic        nline;
        logic        font;
        logic [17:0] bcnt;
        logic        dark;
        logic [7:0]  rd;
        logic [4:0]  pix;
        logic        aload;
        logic [3:0]  brun;
    } cld_s;

    cld_s s_r;
    cld_s s_nxt;

    logic [7:0] text_mem [CLD_TEXT_DEPTH];
    logic [7:0] glyph_mem [CLD_GLYPH_DEPTH];
    logic       text_we;
    logic       glyph_we;
    logic [6:0] text_idx;

    // Fold the two-line map onto 80 cells; second line starts at cell 40
    always_comb
    begin
        if (s_r.nline && s_r.ac >= CLD_LINE2_FIRST)
        begin
            text_idx = 7'(s_r.ac - CLD_LINE2_FIRST + 7'(CLD_TEXT_DEPTH / 2));
        end
        else
        begin
            text_idx = s_r.ac;
        end
    end

    // Step the counter; glyph space is only six bits wide
    function automatic logic [6:0] step_ac(input logic [6:0] a, input logic up,
                                           input logic g, input logic two);
        logic [6:0] n;
        n = up ? 7'(a + 7'h01) : 7'(a - 7'h01);
        if (g)
        begin
            n = {1'b0, n[5:0]};
        end
        else if (two)
        begin
            if (up && a == CLD_LINE1_LAST)
                n = CLD_LINE2_FIRST;
            else if (up && a == CLD_LINE2_LAST)
                n = 7'h00;
            else if (!up && a == CLD_LINE2_FIRST)
                n = CLD_LINE1_LAST;
            else if (!up && a == 7'h00)
                n = CLD_LINE2_LAST;
        end
        else
        begin
            if (up && a == CLD_TEXT_LAST1)
                n = 7'h00;
            else if (!up && a == 7'h00)
                n = CLD_TEXT_LAST1;
        end
        return n;
    endfunction : step_ac

    // Shift offset wraps within the visible ring of one line
    function automatic logic [6:0] step_ofs(input logic [6:0] o, input logic right,
                                            input logic two);
        logic [6:0] lim;
        logic [6:0] n;
        lim = two ? CLD_LINE1_LAST : CLD_TEXT_LAST1;
        if (right)
            n = (o == 7'h00) ? lim : 7'(o - 7'h01);
        else
            n = (o == lim) ? 7'h00 : 7'(o + 7'h01);
        return n;
    endfunction : step_ofs

    always_comb
    begin
        s_nxt = s_r;
        text_we = 1'b0;
        glyph_we = 1'b0;
        if (s_r.bcnt == 18'(BLINK_HALF - 1))
        begin
            s_nxt.bcnt = 18'h00000;
            s_nxt.dark = ~s_r.dark;
        end
        else
        begin
            s_nxt.bcnt = 18'(s_r.bcnt + 18'h00001);
        end
        s_nxt.pix = glyph_mem[pix_addr][4:0];
        // An address-load mark lives only until the machine returns to idle
        if (s_r.st == CLD_IDLE)
            s_nxt.aload = 1'b0;
        // Busy run length; saturates so a stuck busy cannot wrap back into range
        if (!busy_indicator)
            s_nxt.brun = 4'h0;
        else if (s_r.brun != 4'hf)
            s_nxt.brun = 4'(s_r.brun + 4'h1);
        case (s_r.st)
            CLD_IDLE:
            begin
            end
            CLD_BUSY:
            begin
                // hold busy for the execution time
                if (s_r.cnt == 9'h001)
                    s_nxt.st = CLD_IDLE;
                s_nxt.cnt = 9'(s_r.cnt - 9'h001);
            end
            CLD_SETTLE:
            begin
                if (s_r.cnt == 9'h001)
                    s_nxt.st = CLD_IDLE;
                s_nxt.cnt = 9'(s_r.cnt - 9'h001);
            end
            default:
            begin
                s_nxt.st = CLD_IDLE;
            end
        endcase
        // Busy guard: instructions issued while busy are ignored
        if (wr_stb && !register_select && !busy_indicator)
        begin
            s_nxt.st = CLD_BUSY;
            s_nxt.cnt = 9'(CLD_EXEC_CYC);
            s_nxt.aload = wdata[7] | wdata[6];
            if (wdata[7])
            begin
                s_nxt.ac = wdata[6:0];
                s_nxt.glyph = 1'b0;
            end
            else if (wdata[6])
            begin
                s_nxt.ac = {1'b0, wdata[5:0]};
                s_nxt.glyph = 1'b1;
            end
            else if (wdata[5])
            begin
                s_nxt.ifw = wdata[CLD_BIT_IFW];
                s_nxt.nline = wdata[CLD_BIT_NLINE];
                s_nxt.font = wdata[CLD_BIT_FONT];
            end
            else if (wdata[4])
            begin
                if (wdata[CLD_BIT_SC])
                    s_nxt.ofs = step_ofs(s_r.ofs, wdata[CLD_BIT_RL], s_r.nline);
                s_nxt.ac = step_ac(s_r.ac, wdata[CLD_BIT_RL], s_r.glyph, s_r.nline);
            end
            else if (wdata[3])
            begin
                s_nxt.disp = wdata[CLD_BIT_DISP];
                s_nxt.curs = wdata[CLD_BIT_CURS];
                s_nxt.blink = wdata[CLD_BIT_BLINK];
            end
            else if (wdata[2])
            begin
                s_nxt.inc = wdata[CLD_BIT_INC];
                s_nxt.shen = wdata[CLD_BIT_SHEN];
            end
        end
        else if (wr_stb && register_select && !busy_indicator)
        begin
            s_nxt.st = CLD_BUSY;
            s_nxt.cnt = 9'(CLD_EXEC_CYC);
            text_we = ~s_r.glyph;
            glyph_we = s_r.glyph;
            // Data accesses never start a settle phase
            s_nxt.aload = 1'b0;
            s_nxt.ac = step_ac(s_r.ac, s_r.inc, s_r.glyph, s_r.nline);
            // shared display shift opposite to cursor
            if (s_r.shen && !s_r.glyph)
                s_nxt.ofs = step_ofs(s_r.ofs, ~s_r.inc, s_r.nline);
        end
        else if (rd_stb && register_select && !busy_indicator)
        begin
            // data read steps counter, never shifts
            s_nxt.st = CLD_BUSY;
            s_nxt.cnt = 9'(CLD_EXEC_CYC);
            s_nxt.aload = 1'b0;
            s_nxt.rd = s_r.glyph ? glyph_mem[s_r.ac[5:0]] : text_mem[text_idx];
            s_nxt.ac = step_ac(s_r.ac, s_r.inc, s_r.glyph, s_r.nline);
        end
        else if (rd_stb && !register_select)
        begin
            s_nxt.rd = {busy_indicator, s_r.ac};
        end
        // Address loads add a settling phase after busy drops; a status read
        // in that phase already sees the loaded counter, so hosts may poll early
        if (s_r.st == CLD_BUSY && s_r.cnt == 9'h001 && s_r.aload)
        begin
            s_nxt.st = CLD_SETTLE;
            s_nxt.cnt = 9'(CLD_AC_SETTLE);
        end
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            s_r <= '0;
            s_r.st <= CLD_IDLE;
            s_r.ac <= CLD_AC_RST;
            s_r.ofs <= CLD_SHIFT_RST;
            s_r.inc <= 1'b1;
            s_r.ifw <= 1'b1;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    // Memories carry no reset; contents are undefined until written
    always_ff @(posedge clk)
    begin
        if (text_we)
            text_mem[text_idx] <= wdata;
        // all eight bits kept, only low five reach pixels
        if (glyph_we)
            glyph_mem[s_r.ac[5:0]] <= wdata;
    end

    // Busy stays up through execution only; settle phase reads as ready
    assign busy_indicator = (s_r.st == CLD_BUSY);
    assign rdata = s_r.rd;
    assign addr_count = s_r.ac;
    assign sel_glyph = s_r.glyph;
    assign shift_ofs = s_r.ofs;
    assign disp_on = s_r.disp;
    assign cursor_on = s_r.curs;
    assign blink_on = s_r.blink;
    // dark phase only when blinking is on
    assign blink_dark = s_r.blink & s_r.dark;
    assign bus_8bit = s_r.ifw;
    assign two_line = s_r.nline;
    assign duty_coms = s_r.nline ? CLD_DUTY_16 : (s_r.font ? CLD_DUTY_11 : CLD_DUTY_8);
    assign pix_row = s_r.pix;

    // busy lasts exactly the execution time
    a_busy_len: assert property (@(posedge clk) disable iff (!nrst)
        $fell(busy_indicator) |-> s_r.brun == 4'(CLD_EXEC_CYC))
        else $error("busy length wrong");
    a_busy_cap: assert property (@(posedge clk) disable iff (!nrst)
        busy_indicator |-> s_r.brun < 4'(CLD_EXEC_CYC))
        else $error("busy held too long");
    a_glyph_wrap: assert property (@(posedge clk) disable iff (!nrst)
        sel_glyph |-> addr_count[6] == 1'b0)
        else $error("glyph counter above six bits");
    a_text_load: assert property (@(posedge clk) disable iff (!nrst)
        (wr_stb && !register_select && !busy_indicator && wdata[7])
        |=> addr_count == $past(wdata[6:0]) && !sel_glyph)
        else $error("text address load failed");
    a_glyph_load: assert property (@(posedge clk) disable iff (!nrst)
        (wr_stb && !register_select && !busy_indicator && wdata[7:6] == 2'b01)
        |=> addr_count == {1'b0, $past(wdata[5:0])} && sel_glyph)
        else $error("glyph address load failed");
    a_read_noshift: assert property (@(posedge clk) disable iff (!nrst)
        (rd_stb && register_select) |=> $stable(shift_ofs))
        else $error("read shifted display");
    a_status_read: assert property (@(posedge clk) disable iff (!nrst)
        (rd_stb && !register_select) |=> rdata == {$past(busy_indicator), $past(addr_count)})
        else $error("status word wrong");
    a_glyph_noshift: assert property (@(posedge clk) disable iff (!nrst)
        (wr_stb && register_select && sel_glyph) |=> $stable(shift_ofs))
        else $error("glyph access shifted display");
    a_inc_step: assert property (@(posedge clk) disable iff (!nrst)
        (wr_stb && register_select && !busy_indicator && !sel_glyph && s_r.inc
         && addr_count == 7'h05) |=> addr_count == 7'h06)
        else $error("increment step wrong");
    a_duty_sel: assert property (@(posedge clk) disable iff (!nrst)
        two_line |-> duty_coms == CLD_DUTY_16)
        else $error("duty wrong");

    c_data_write: cover property (@(posedge clk) disable iff (!nrst)
        wr_stb && register_select && !busy_indicator);
    c_data_read: cover property (@(posedge clk) disable iff (!nrst)
        rd_stb && register_select && !busy_indicator);
    c_settle: cover property (@(posedge clk) disable iff (!nrst) s_r.st == CLD_SETTLE);
    c_shift: cover property (@(posedge clk) disable iff (!nrst) $changed(shift_ofs));
    // Both lines shifting together
    c_two_line_shift: cover property (@(posedge clk) disable iff (!nrst)
        two_line && $changed(shift_ofs));
endmodule : cld_decoder

// >>> design/cld_pkg.sv
// Purpose: Shared constants for the character display instruction decoder.
// Assumes: 40 MHz system clock; oscillator clock counted as system clock cycles.
// Notes:   Timing figures are in oscillator clocks; one oscillator clock = one clk.
package cld_pkg;
    // Instruction code leaders (most significant set bit)
    localparam logic [7:0] CLD_OP_ENTRY  = 8'h04;
    localparam logic [7:0] CLD_OP_ONOFF  = 8'h08;
    localparam logic [7:0] CLD_OP_SHIFT  = 8'h10;
    localparam logic [7:0] CLD_OP_SYSSET = 8'h20;
    localparam logic [7:0] CLD_OP_GLYPH  = 8'h40;
    localparam logic [7:0] CLD_OP_TEXT   = 8'h80;
    // Field positions
    localparam int CLD_BIT_INC     = 1;
    localparam int CLD_BIT_SHEN    = 0;
    localparam int CLD_BIT_DISP    = 2;
    localparam int CLD_BIT_CURS    = 1;
    localparam int CLD_BIT_BLINK   = 0;
    localparam int CLD_BIT_SC      = 3;
    localparam int CLD_BIT_RL      = 2;
    localparam int CLD_BIT_IFW     = 4;
    localparam int CLD_BIT_NLINE   = 3;
    localparam int CLD_BIT_FONT    = 2;
    // Address map
    localparam logic [6:0] CLD_TEXT_LAST1 = 7'h4f;
    localparam logic [6:0] CLD_LINE1_LAST = 7'h27;
    localparam logic [6:0] CLD_LINE2_FIRST = 7'h40;
    localparam logic [6:0] CLD_LINE2_LAST = 7'h67;
    localparam int CLD_TEXT_DEPTH  = 80;
    localparam int CLD_GLYPH_DEPTH = 64;
    // Timing in oscillator clocks
    localparam int CLD_EXEC_CYC    = 10;
    localparam int CLD_AC_SETTLE   = 5;
    localparam int CLD_BLINK_PER   = 204800;
    localparam int CLD_BLINK_HALF  = CLD_BLINK_PER / 2;
    // Reset values
    localparam logic [6:0] CLD_AC_RST  = 7'h00;
    localparam logic [6:0] CLD_SHIFT_RST = 7'h00;
    // Duty encodings (number of active commons)
    localparam logic [4:0] CLD_DUTY_8  = 5'h08;
    localparam logic [4:0] CLD_DUTY_11 = 5'h0b;
    localparam logic [4:0] CLD_DUTY_16 = 5'h10;

    typedef enum logic [1:0] {
        CLD_IDLE   = 2'b00,
        CLD_BUSY   = 2'b01,
        CLD_SETTLE = 2'b10
    } cld_state_e;
endpackage : cld_pkg

// >>> sim/cld_host.sv
// Purpose: Host processor model driving the decoder's parallel port.
// Assumes: Each task is entered just after a rising clock edge.
// Notes:   Released data lines show the inverse of the last word, not a held value.
`timescale 1ns/1ps
module cld_host
(
    // Clock and answers
    input  wire logic       clk,
    input  wire logic       busy_indicator,
    input  wire logic [7:0] rdata,
    // Bus drive
    output logic            register_select,
    output logic      [7:0] wdata,
    output logic            wr_stb,
    output logic            rd_stb,
    // Wait bound used up
    output logic            hang
);
    initial
    begin
        register_select = 1'b0;
        wdata           = 8'h00;
        wr_stb          = 1'b0;
        rd_stb          = 1'b0;
        hang            = 1'b0;
    end

    task automatic idle();
        int n;
        n = 0;
        while (busy_indicator !== 1'b0 && n < 100)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        if (n >= 100)
            hang = 1'b1;
        repeat (5) @(posedge clk);
        #1;
    endtask : idle

    task automatic wr(input logic rs, input logic [7:0] d, input bit wt);
        @(posedge clk);
        register_select <= rs;
        wdata           <= d;
        wr_stb          <= 1'b1;
        @(posedge clk);
        wr_stb          <= 1'b0;
        wdata           <= ~d;
        #1;
        if (wt)
            idle();
    endtask : wr

    task automatic rd(input logic rs, output logic [7:0] q, input bit wt);
        @(posedge clk);
        register_select <= rs;
        rd_stb          <= 1'b1;
        @(posedge clk);
        rd_stb          <= 1'b0;
        #1;
        q = rdata;
        if (wt)
            idle();
    endtask : rd
endmodule : cld_host

// >>> sim/char_lcd_instruction_decoder_test.sv
// Purpose: Self-checking bench for the display instruction decoder.
// Assumes: Blink half period shortened to 8 clocks.
// Notes:   Mode commands run from a row table; address and data paths are hand-written.
`timescale 1ns/1ps
module char_lcd_instruction_decoder_test;
    localparam int BH = 8;
    typedef struct packed {
        logic [7:0] cmd;
        logic [9:0] exp;
    } cld_row_s;

    logic       clk;
    logic       nrst;
    logic       register_select;
    logic [7:0] wdata;
    logic       wr_stb;
    logic       rd_stb;
    logic [7:0] rdata;
    logic       busy_indicator;
    logic [6:0] addr_count;
    logic       sel_glyph;
    logic [6:0] shift_ofs;
    logic       disp_on;
    logic       cursor_on;
    logic       blink_on;
    logic       blink_dark;
    logic       bus_8bit;
    logic       two_line;
    logic [4:0] duty_coms;
    logic [5:0] pix_addr;
    logic [4:0] pix_row;
    logic       hang;
    int         n_fail;
    int         n_tests;
    int         i;
    int         n;
    logic [7:0] q;
    logic [6:0] s0;
    logic [6:0] a0;
    logic [6:0] dl;
    logic [7:0] sc [4] = '{8'h1b, 8'h1e, 8'h11, 8'h16};
    cld_row_s   rows [12];

    cld_decoder #(.BLINK_HALF(BH)) dut (
        .clk(clk), .nrst(nrst), .register_select(register_select), .wdata(wdata),
        .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .busy_indicator(busy_indicator),
        .addr_count(addr_count), .sel_glyph(sel_glyph), .shift_ofs(shift_ofs),
        .disp_on(disp_on), .cursor_on(cursor_on), .blink_on(blink_on),
        .blink_dark(blink_dark), .bus_8bit(bus_8bit), .two_line(two_line),
        .duty_coms(duty_coms), .pix_addr(pix_addr), .pix_row(pix_row)
    );

    cld_host host (
        .clk(clk), .busy_indicator(busy_indicator), .rdata(rdata),
        .register_select(register_select), .wdata(wdata), .wr_stb(wr_stb),
        .rd_stb(rd_stb), .hang(hang)
    );

    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic final_report();
        $display("Checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : final_report

    task automatic do_reset();
        @(posedge clk);
        nrst <= 1'b0;
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        #1;
        chk("reset state", {busy_indicator, addr_count, sel_glyph, shift_ofs}, 16'h0);
        chk("reset modes", {disp_on, cursor_on, blink_on, blink_dark, bus_8bit, two_line,
            duty_coms}, {6'b000010, 5'h08});
    endtask : do_reset

    // Cycles until blink_dark next changes, bounded
    task automatic wchg(output int cnt);
        logic b;
        b = blink_dark;
        cnt = 0;
        do
        begin
            @(posedge clk);
            #1;
            cnt++;
        end while (blink_dark === b && cnt < 40);
        if (cnt >= 40)
            n_fail++;
    endtask : wchg

    always @(posedge hang)
    begin
        n_fail++;
        final_report();
    end

    initial
    begin
        nrst     = 1'b0;
        pix_addr = 6'h00;
        n_fail   = 0;
        n_tests  = 0;
        rows[0]  = '{8'h30, {3'b000, 2'b10, 5'h08}};
        rows[1]  = '{8'h34, {3'b000, 2'b10, 5'h0b}};
        rows[2]  = '{8'h2b, {3'b000, 2'b01, 5'h10}};
        rows[3]  = '{8'h3c, {3'b000, 2'b11, 5'h10}};
        for (i = 0; i < 8; i++)
            rows[4 + i] = '{8'h08 | 8'(i), {i[2:0], 2'b11, 5'h10}};
        do_reset();
        // System set leads; later rows walk every on/off combination
        for (i = 0; i < 12; i++)
        begin
            host.wr(1'b0, rows[i].cmd, 1'b1);
            chk("mode flags", {disp_on, cursor_on, blink_on, bus_8bit, two_line, duty_coms},
                16'(rows[i].exp));
        end
        // Second command lands while busy and must be dropped
        host.wr(1'b0, 8'h0e, 1'b0);
        host.wr(1'b0, 8'h08, 1'b0);
        host.rd(1'b0, q, 1'b0);
        chk("busy in status", q[7], 1'b1);
        host.idle();
        chk("flags after refusal", {disp_on, cursor_on, blink_on}, 3'b110);
        host.wr(1'b0, 8'h06, 1'b1);
        host.wr(1'b0, 8'h85, 1'b1);
        chk("text address", {sel_glyph, addr_count}, 8'h05);
        s0 = shift_ofs;
        host.wr(1'b1, 8'h41, 1'b1);
        chk("cursor write step", {shift_ofs, addr_count}, {s0, 7'h06});
        host.wr(1'b0, 8'h07, 1'b1);
        host.wr(1'b1, 8'h42, 1'b1);
        dl = 7'(shift_ofs - s0);
        chk("display write step", {dl === 7'h01 || dl === 7'h7f, addr_count},
            {1'b1, 7'h07});
        // Left display shift must match the entry-mode shift
        for (i = 0; i < 4; i++)
        begin
            s0 = shift_ofs;
            a0 = addr_count;
            host.wr(1'b0, sc[i], 1'b1);
            chk("shift offset", 7'(shift_ofs - s0), i[1] ? 7'h0 : (i[0] ? 7'(-dl) : dl));
            chk("cursor move", 7'(addr_count - a0), i[0] ? 7'h01 : 7'h7f);
        end
        host.wr(1'b0, 8'h05, 1'b1);
        s0 = shift_ofs;
        host.wr(1'b0, 8'h86, 1'b1);
        host.rd(1'b0, q, 1'b0);
        chk("status after load", q, 8'h06);
        host.rd(1'b1, q, 1'b1);
        chk("text read", {q, shift_ofs, addr_count}, {8'h42, s0, 7'h05});
        host.wr(1'b0, 8'h85, 1'b1);
        host.rd(1'b1, q, 1'b1);
        chk("text read dec", {q, shift_ofs, addr_count}, {8'h41, s0, 7'h04});
        host.wr(1'b0, 8'h0d, 1'b1);
        wchg(n);
        wchg(n);
        chk("blink half period", 16'(n), 16'(BH));
        host.wr(1'b0, 8'h08, 1'b1);
        chk("blink off", blink_dark, 1'b0);
        host.wr(1'b0, 8'h0c, 1'b1);
        host.wr(1'b0, 8'h07, 1'b1);
        host.wr(1'b0, 8'h7f, 1'b1);
        chk("glyph address", {sel_glyph, addr_count}, 8'hbf);
        host.wr(1'b1, 8'hff, 1'b1);
        chk("glyph wrap", {shift_ofs, addr_count}, {s0, 7'h00});
        host.wr(1'b1, 8'he0, 1'b1);
        chk("glyph step", addr_count, 7'h01);
        @(posedge clk);
        pix_addr <= 6'h3f;
        @(posedge clk);
        pix_addr <= 6'h00;
        #1;
        chk("glyph row full", pix_row, 5'h1f);
        @(posedge clk);
        #1;
        chk("glyph row masked", pix_row, 5'h00);
        host.wr(1'b0, 8'h7f, 1'b1);
        host.rd(1'b1, q, 1'b1);
        chk("glyph read", {q, addr_count}, {8'hff, 7'h00});
        host.wr(1'b0, 8'h06, 1'b1);
        host.wr(1'b0, 8'ha7, 1'b1);
        host.wr(1'b1, 8'h33, 1'b1);
        chk("line one end wrap", addr_count, 7'h40);
        host.wr(1'b0, 8'he7, 1'b1);
        host.wr(1'b1, 8'h55, 1'b1);
        host.wr(1'b0, 8'he7, 1'b1);
        host.rd(1'b1, q, 1'b1);
        chk("line two end", {q, addr_count}, {8'h55, 7'h00});
        do_reset();
        host.wr(1'b0, 8'h38, 1'b1);
        chk("config after reset", {two_line, duty_coms}, {1'b1, 5'h10});
        final_report();
    end
endmodule : char_lcd_instruction_decoder_test
